/* File: hw/drive_io_pkg.sv */
// Shared constants and carrier types for the drive pulse output and input status block.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package drive_io_pkg;

   // Clock rate
   localparam int unsigned CLK_HZ            = 250_000_000;

   // Pulse output source codes
   localparam logic [4:0] SRC_SPEED_REF      = 5'h00;
   localparam logic [4:0] SRC_REAL_SPEED     = 5'h02;
   localparam logic [4:0] SRC_OUT_CURRENT    = 5'h05;
   localparam logic [4:0] SRC_PROC_VAR       = 5'h06;
   localparam logic [4:0] SRC_ACT_CURRENT    = 5'h07;
   localparam logic [4:0] SRC_PID_SETPOINT   = 5'h09;
   localparam logic [4:0] SRC_TORQUE         = 5'h0B;
   localparam logic [4:0] SRC_USER_PROG      = 5'h0C;
   localparam logic [4:0] SRC_INACTIVE       = 5'h0F;
   localparam logic [4:0] SRC_OVERLOAD       = 5'h10;
   localparam logic [4:0] SRC_USER_A         = 5'h12;
   localparam logic [4:0] SRC_USER_B         = 5'h13;
   localparam logic [4:0] SRC_USER_C         = 5'h14;

   // Full-scale constants
   localparam logic [15:0] USER_FULL_SCALE   = 16'h7FFF;
   localparam logic [15:0] TORQUE_FULL_SCALE = 16'h07D0;  // 200.0 % in 0.1 % steps
   localparam logic [15:0] OVERLOAD_FULL     = 16'h03E8;  // 100.0 % in 0.1 % steps

   // Gain is in thousandths
   localparam logic [13:0] GAIN_UNITY        = 14'h03E8;
   localparam logic [13:0] GAIN_MAX          = 14'h270F;
   localparam logic [14:0] FREQ_LIMIT_LO     = 15'h000A;
   localparam logic [14:0] FREQ_LIMIT_HI     = 15'h4E20;
   localparam logic [14:0] MIN_FREQ_RESET    = 15'h000A;
   localparam logic [14:0] MAX_FREQ_RESET    = 15'h2710;

   // Settings after reset
   localparam logic [4:0] SOURCE_RESET       = 5'h0F;
   localparam logic [3:0] LEVEL_RESET        = 4'h0;
   localparam logic       PIN_IDLE_RESET     = 1'b1;  // Synchroniser level of a released sink pin
   localparam logic [3:0] LEVEL_ALL_SOURCE   = 4'h8;
   localparam int unsigned NUM_INPUTS        = 8;
   localparam logic [5:0] FUNC_MAX           = 6'h2E;
   localparam logic [5:0] FUNC1_RESET        = 6'h01;
   localparam logic [5:0] FUNC2_RESET        = 6'h08;
   localparam logic [5:0] FUNC3_RESET        = 6'h14;
   localparam logic [5:0] FUNC4_RESET        = 6'h0A;
   localparam logic [5:0] FUNC_OTHER_RESET   = 6'h00;
   localparam int unsigned PIN2_INDEX        = 1;

   // Internal quantities presented to the pulse output
   typedef struct packed {
      logic [15:0] speed_ref;
      logic [15:0] real_speed;
      logic [15:0] out_current;
      logic [15:0] proc_var;
      logic [15:0] act_current;
      logic [15:0] pid_setpoint;
      logic [15:0] torque;
      logic [15:0] user_prog;
      logic [15:0] overload;
   } drive_quantities_t;

   // Full-scale settings of the drive
   typedef struct packed {
      logic [15:0] max_speed_setting;
      logic [15:0] rated_current_setting;
      logic [15:0] pid_full_scale_setting;
   } scale_settings_t;

   // Pulse output configuration
   typedef struct packed {
      logic [4:0]  pulse_out_source_select;
      logic [13:0] pulse_out_gain;
      logic [14:0] pulse_out_min_freq;
      logic [14:0] pulse_out_max_freq;
      logic [15:0] user_output_value_a;
      logic [15:0] user_output_value_b;
      logic [15:0] user_output_value_c;
   } pulse_config_t;

endpackage

/* File: hw/input_conditioner.sv */
// One digital input: two-stage synchroniser followed by active-level selection.
// Assumes the pin is asynchronous to CLK_SYS.
`timescale 1ns/10ps
module input_conditioner
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin_in,
   input  wire logic source_type,
   output logic      active
);

   // Whole state of one input
   typedef struct packed {
      logic meta;
      logic sync;
      logic act;
   } cond_state_t;

   cond_state_t state_q;  // Registered state
   cond_state_t state_d;  // Next state

   // First stage feeds only the second; polarity acts on the settled copy
   always_comb
   begin
      state_d      = state_q;
      state_d.meta = pin_in;
      state_d.sync = state_q.meta;
      // Source-type is active high, sink-type is active on a low pin
      state_d.act  = source_type ? state_q.sync : ~state_q.sync;
   end

   // Register the state; the synchroniser resets to a released sink pin so no sink-type
   // input reads active before the first real sample has crossed both stages
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q      <= '0;
         state_q.meta <= drive_io_pkg::PIN_IDLE_RESET;
         state_q.sync <= drive_io_pkg::PIN_IDLE_RESET;
      end
      else
         state_q <= state_d;
   end

   assign active = state_q.act;

endmodule

/* File: hw/pulse_generator.sv */
// Square wave generator whose half period is loaded as a cycle count.
// Assumes the count is at least one and changes only between half periods.
`timescale 1ns/10ps
module pulse_generator
#(
   parameter int CNT_W = 24
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] half_period,
   output logic                  wave
);

   // Counter and output level
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             level;
   } gen_state_t;

   gen_state_t state_q;  // Registered state
   gen_state_t state_d;  // Next state

   // Toggle the level each time the count plus one reaches the half period
   always_comb
   begin
      state_d = state_q;
      if (!run)
      begin
         state_d = '0;
      end
      else if (state_q.count + CNT_W'(1) >= half_period)
      begin
         state_d.count = '0;
         state_d.level = ~state_q.level;
      end
      else
      begin
         state_d.count = state_q.count + CNT_W'(1);
      end
   end

   // Register the state
   always_ff @(posedge clk)
   begin
      if (rst)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign wave = state_q.level;

endmodule

/* File: hw/drive_pulse_output_and_input_status.sv */
// Transistor output selection with pulse-frequency output, and digital input status.
// Assumes parameter inputs are static settings on CLK_SYS; pins are asynchronous.
//
// Operation
// - Source 15 gives plain digital output
// - Other sources give pulse output only
// - Speeds scale to maximum speed setting
// - Currents full scale at twice rated
// - Torque full scale is 200 percent
// - User program 32767 gives full scale
// - Sources 18 to 20 use user values
// - Gain and frequency limits with defaults; here both come from PULSE_CONFIG and no defaults are loaded
// - Up to eight inputs, per fitted module
// - Level setting n makes inputs 1..n source
// - Sink active low, source active high
// - Input x reports in bit x-1
// - Status shows activity after polarity
// - Status byte is read-only hexadecimal
// - Eight function selectors, 0 to 46
// - Pulse input masks input two
`timescale 1ns/10ps
module drive_pulse_output_and_input_status
#(
   parameter int NUM_PRESENT = 8  // Inputs present on the fitted module
)
(
   input  wire logic                               CLK_SYS,
   input  wire logic                               RESET,
   input  wire drive_io_pkg::drive_quantities_t    QUANTITIES,
   input  wire drive_io_pkg::scale_settings_t      SCALES,
   input  wire drive_io_pkg::pulse_config_t        PULSE_CONFIG,
   input  wire logic                               TRANSISTOR_OUT_FUNCTION,
   input  wire logic                               PULSE_IN_ENABLE,
   input  wire logic [3:0]                         INPUT_ACTIVE_LEVEL_SELECT,
   input  wire logic [47:0]                        INPUT_FUNCTION_SELECT,
   input  wire logic                               FUNCTION_SELECT_WRITE,
   input  wire logic [7:0]                         NUMBERED_INPUT_PIN,
   output logic                                    TRANSISTOR_OUTPUT_TWO,
   output logic                                    PULSE_OUT_ACTIVE,
   output logic [15:0]                             PULSE_OUT_FREQ_HZ,
   output logic [7:0]                              INPUT_STATUS_BYTE,
   output logic [47:0]                             INPUT_FUNCTION_ACTIVE
);

   localparam int CNT_W = 24;  // Half period count width
   localparam logic [31:0] CLK_HALF = 32'(drive_io_pkg::CLK_HZ / 2);

   // All registered state of the top
   typedef struct packed {
      logic [3:0]  level_sel;   // Active-level setting
      logic [47:0] func_sel;    // Function selectors, six bits per input
      logic [7:0]  status;      // Input status byte
      logic [15:0] fraction;    // Scaled source, 0..65535 as 0..100 %
      logic [15:0] freq_hz;     // Target frequency
      logic [CNT_W-1:0] half;   // Half period in cycles
      logic        pulse_run;   // Pulse output enabled
      logic        out_pin;     // Transistor output level
      logic [47:0] func_view;   // Selectors as presented
   } top_state_t;

   top_state_t state_q;  // Registered state
   top_state_t state_d;  // Next state

   logic [7:0] source_type;  // Per-input source-type flag
   logic [7:0] active;       // Conditioned input activity
   logic       wave;         // Generated pulse wave

   // Scaled value over full scale as a 16-bit fraction, saturating at one
   function automatic logic [15:0] scale_to(input logic [15:0] val, input logic [16:0] full);
      logic [32:0] q;
      q = 33'h0_0000_0000;
      if (full != 17'h0_0000)
         q = ({17'h0_0000, val} << 16) / {16'h0000, full};
      scale_to = (q > 33'h0_0000_FFFF) ? 16'hFFFF : q[15:0];
   endfunction

   // Source-type flags from the level setting: inputs 1..n are source-type
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         source_type[i] = (state_q.level_sel >= drive_io_pkg::LEVEL_ALL_SOURCE) ||
                          (32'(state_q.level_sel) > i);
   end

   // One conditioner per input pin
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : gen_in
         input_conditioner u_cond
         (
            .clk         (CLK_SYS),
            .rst         (RESET),
            .pin_in      (NUMBERED_INPUT_PIN[g]),
            .source_type (source_type[g]),
            .active      (active[g])
         );
      end
   endgenerate

   // Pulse wave generator for the transistor output
   pulse_generator #(.CNT_W(CNT_W)) u_gen
   (
      .clk         (CLK_SYS),
      .rst         (RESET),
      .run         (state_q.pulse_run),
      .half_period (state_q.half),
      .wave        (wave)
   );

   // Next state: settings capture, source scaling, frequency map, status byte
   always_comb
   begin
      logic [16:0] two_rated;
      logic [15:0] frac;
      logic [29:0] gained;
      logic [15:0] g_frac;
      logic [14:0] fmin;
      logic [14:0] fmax;
      logic [31:0] span;
      logic [15:0] freq;
      logic [5:0]  f;
      state_d   = state_q;
      two_rated = {SCALES.rated_current_setting, 1'b0};
      frac      = 16'h0000;
      f         = 6'h00;
      gained    = 30'h0000_0000;
      g_frac    = 16'h0000;
      fmin      = 15'h0000;
      fmax      = 15'h0000;
      span      = 32'h0000_0000;
      freq      = 16'h0000;
      // Level setting above all-source is clamped to all-source
      state_d.level_sel = (INPUT_ACTIVE_LEVEL_SELECT > drive_io_pkg::LEVEL_ALL_SOURCE) ?
                          drive_io_pkg::LEVEL_ALL_SOURCE : INPUT_ACTIVE_LEVEL_SELECT;
      // Function selectors accept only 0..46; out-of-range writes are dropped
      if (FUNCTION_SELECT_WRITE)
      begin
         for (int i = 0; i < 8; i++)
         begin
            f = INPUT_FUNCTION_SELECT[i*6 +: 6];
            if (f <= drive_io_pkg::FUNC_MAX)
               state_d.func_sel[i*6 +: 6] = f;
         end
      end
      // Source scaling to a fraction of full scale
      case (PULSE_CONFIG.pulse_out_source_select)
         drive_io_pkg::SRC_SPEED_REF:
            frac = scale_to(QUANTITIES.speed_ref, {1'b0, SCALES.max_speed_setting});
         drive_io_pkg::SRC_REAL_SPEED:
            frac = scale_to(QUANTITIES.real_speed, {1'b0, SCALES.max_speed_setting});
         drive_io_pkg::SRC_OUT_CURRENT:
            frac = scale_to(QUANTITIES.out_current, two_rated);
         drive_io_pkg::SRC_ACT_CURRENT:
            frac = scale_to(QUANTITIES.act_current, two_rated);
         drive_io_pkg::SRC_PROC_VAR:
            frac = scale_to(QUANTITIES.proc_var, {1'b0, SCALES.pid_full_scale_setting});
         drive_io_pkg::SRC_PID_SETPOINT:
            frac = scale_to(QUANTITIES.pid_setpoint, {1'b0, SCALES.pid_full_scale_setting});
         drive_io_pkg::SRC_TORQUE:
            frac = scale_to(QUANTITIES.torque, {1'b0, drive_io_pkg::TORQUE_FULL_SCALE});
         drive_io_pkg::SRC_USER_PROG:
            frac = scale_to(QUANTITIES.user_prog, {1'b0, drive_io_pkg::USER_FULL_SCALE});
         drive_io_pkg::SRC_OVERLOAD:
            frac = scale_to(QUANTITIES.overload, {1'b0, drive_io_pkg::OVERLOAD_FULL});
         drive_io_pkg::SRC_USER_A:
            frac = scale_to(PULSE_CONFIG.user_output_value_a,
                            {1'b0, drive_io_pkg::USER_FULL_SCALE});
         drive_io_pkg::SRC_USER_B:
            frac = scale_to(PULSE_CONFIG.user_output_value_b,
                            {1'b0, drive_io_pkg::USER_FULL_SCALE});
         drive_io_pkg::SRC_USER_C:
            frac = scale_to(PULSE_CONFIG.user_output_value_c,
                            {1'b0, drive_io_pkg::USER_FULL_SCALE});
         default:
            frac = 16'h0000;  // Unused codes output zero
      endcase
      state_d.fraction = frac;
      // Gain in thousandths, clamped to its range, result saturates at full scale
      gained = 30'(state_q.fraction) *
               30'((PULSE_CONFIG.pulse_out_gain > drive_io_pkg::GAIN_MAX) ?
                   drive_io_pkg::GAIN_MAX : PULSE_CONFIG.pulse_out_gain);
      gained = gained / 30'(drive_io_pkg::GAIN_UNITY);
      g_frac = (gained > 30'h0000_FFFF) ? 16'hFFFF : gained[15:0];
      // Frequency limits kept inside 10..20000 Hz
      fmin = (PULSE_CONFIG.pulse_out_min_freq < drive_io_pkg::FREQ_LIMIT_LO) ?
             drive_io_pkg::FREQ_LIMIT_LO :
             (PULSE_CONFIG.pulse_out_min_freq > drive_io_pkg::FREQ_LIMIT_HI) ?
             drive_io_pkg::FREQ_LIMIT_HI : PULSE_CONFIG.pulse_out_min_freq;
      fmax = (PULSE_CONFIG.pulse_out_max_freq < fmin) ? fmin :
             (PULSE_CONFIG.pulse_out_max_freq > drive_io_pkg::FREQ_LIMIT_HI) ?
             drive_io_pkg::FREQ_LIMIT_HI : PULSE_CONFIG.pulse_out_max_freq;
      // A saturated fraction means full scale: land exactly on the upper limit
      if (g_frac == 16'hFFFF)
         span = 32'(fmax - fmin);
      else
         span = (32'(fmax - fmin) * 32'(g_frac)) >> 16;
      freq = 16'(32'(fmin) + span);
      state_d.freq_hz = freq;
      // Half period in cycles; the zero freq left by reset is read as 10 Hz
      state_d.half = CNT_W'(CLK_HALF / 32'(state_q.freq_hz == 16'h0000 ?
                                           16'h000A : state_q.freq_hz));
      state_d.pulse_run = (PULSE_CONFIG.pulse_out_source_select != drive_io_pkg::SRC_INACTIVE);
      // Inactive code passes the digital function; otherwise the wave owns the pin
      if (state_q.pulse_run)
         state_d.out_pin = wave;
      else
         state_d.out_pin = TRANSISTOR_OUT_FUNCTION;
      // Status byte: bit x-1 for input x, after polarity, absent inputs read zero
      for (int i = 0; i < 8; i++)
         state_d.status[i] = (i < NUM_PRESENT) ? active[i] : 1'b0;
      // Pulse input owns the second pin: its bit stays zero
      if (PULSE_IN_ENABLE)
         state_d.status[drive_io_pkg::PIN2_INDEX] = 1'b0;
      // Second input's selector reads zero while the pulse input owns that pin
      state_d.func_view = state_q.func_sel;
      if (PULSE_IN_ENABLE)
         state_d.func_view[drive_io_pkg::PIN2_INDEX*6 +: 6] = 6'h00;
   end

   // Register the state; reset loads the documented defaults
   always_ff @(posedge CLK_SYS)
   begin
      if (RESET)
      begin
         state_q           <= '0;
         state_q.level_sel <= drive_io_pkg::LEVEL_RESET;
         state_q.func_sel  <= {drive_io_pkg::FUNC_OTHER_RESET, drive_io_pkg::FUNC_OTHER_RESET,
                               drive_io_pkg::FUNC_OTHER_RESET, drive_io_pkg::FUNC_OTHER_RESET,
                               drive_io_pkg::FUNC4_RESET, drive_io_pkg::FUNC3_RESET,
                               drive_io_pkg::FUNC2_RESET, drive_io_pkg::FUNC1_RESET};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Outputs straight from flip-flops; status is read-only, shown as hex by software
   assign TRANSISTOR_OUTPUT_TWO = state_q.out_pin;
   assign PULSE_OUT_ACTIVE      = state_q.pulse_run;
   assign PULSE_OUT_FREQ_HZ     = state_q.freq_hz;
   assign INPUT_STATUS_BYTE     = state_q.status;
   assign INPUT_FUNCTION_ACTIVE = state_q.func_view;

   // Inactive code means the pin follows the digital function one cycle later
   AST_DIGITAL_PASS: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (PULSE_CONFIG.pulse_out_source_select == drive_io_pkg::SRC_INACTIVE) [*3]
      |-> TRANSISTOR_OUTPUT_TWO == $past(TRANSISTOR_OUT_FUNCTION))
      else $error("transistor output does not follow digital function");

   // Once the pulse output starts, the pin carries the wave with one edge of lag
   AST_PULSE_OWNS: assert property (@(posedge CLK_SYS) disable iff (RESET)
      $rose(PULSE_OUT_ACTIVE) |-> ##1 TRANSISTOR_OUTPUT_TWO == $past(wave))
      else $error("pulse wave not on transistor output");

   // Pulse input forces the second status bit low at the next edge
   AST_STATUS_MASK: assert property (@(posedge CLK_SYS) disable iff (RESET)
      PULSE_IN_ENABLE |=> !INPUT_STATUS_BYTE[1])
      else $error("status bit one set while pulse input enabled");

   // Pulse input hides the second input's selector at the next edge
   AST_FUNC_MASK: assert property (@(posedge CLK_SYS) disable iff (RESET)
      PULSE_IN_ENABLE |=> INPUT_FUNCTION_ACTIVE[11:6] == 6'h00)
      else $error("input two function not ignored");

   // A low sink pin held through the whole pipeline reads active
   AST_SINK_LOW: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (state_q.level_sel == 4'h0 && NUMBERED_INPUT_PIN[0] == 1'b0) [*8]
      |-> (NUM_PRESENT == 0 || INPUT_STATUS_BYTE[0]))
      else $error("sink input low not reported active");

   // With every input source-type, a high pin held long enough reads active
   AST_SOURCE_HIGH: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (state_q.level_sel == 4'h8 && NUMBERED_INPUT_PIN[0]) [*8]
      |-> (NUM_PRESENT == 0 || INPUT_STATUS_BYTE[0]))
      else $error("source input high not reported active");

   // Frequency stays inside its limits once a post-reset value is loaded
   AST_FREQ_RANGE: assert property (@(posedge CLK_SYS) disable iff (RESET)
      !$past(RESET) |-> (PULSE_OUT_FREQ_HZ >= 16'h000A && PULSE_OUT_FREQ_HZ <= 16'h4E20))
      else $error("pulse frequency out of range");

   // The first and last stored selectors never leave their range
   AST_FUNC_RANGE: assert property (@(posedge CLK_SYS) disable iff (RESET)
      state_q.func_sel[5:0] <= 6'h2E && state_q.func_sel[47:42] <= 6'h2E)
      else $error("function selector out of range");

   // Absent inputs never report activity
   AST_ABSENT_ZERO: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (INPUT_STATUS_BYTE >> NUM_PRESENT) == 8'h00)
      else $error("status bit set for an absent input");

   // Inactive source code stops the pulse output at the next edge
   AST_PULSE_IDLE: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (PULSE_CONFIG.pulse_out_source_select == drive_io_pkg::SRC_INACTIVE)
      |=> !PULSE_OUT_ACTIVE)
      else $error("pulse output still active on inactive source");

   // Any other code hands the transistor output to the pulse generator
   AST_PULSE_ON: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (!RESET && PULSE_CONFIG.pulse_out_source_select != drive_io_pkg::SRC_INACTIVE)
      |=> PULSE_OUT_ACTIVE)
      else $error("pulse output not active on a pulse source");

endmodule

/* File: bench/field_equipment.sv */
// Field side model: input switches and a pulse receiver on the transistor output.
// Assumes the bench sets the raw pin levels; the receiver samples on the system clock.
`timescale 1ns/10ps
module field_equipment
(
   input  wire logic       clk,
   input  wire logic       clr,
   input  wire logic [7:0] raw_level,
   input  wire logic       out_pin,
   output logic [7:0]      pins,
   output int              rise_cnt
);
   logic last_q;  // Previous sample of the output pin
   // Switch wiring lags the clock so pins really arrive off the edge
   assign #1.3 pins = raw_level;
   // Receiver counts rising edges of the pulse output
   always_ff @(posedge clk)
   begin
      last_q <= out_pin;
      if (clr)
         rise_cnt <= 0;
      else if (out_pin && !last_q)
         rise_cnt <= rise_cnt + 1;
   end
endmodule

/* File: bench/tb_drive_pulse_output_and_input_status.sv */
// Self-checking bench for the transistor output selection and input status.
// Assumes field_equipment drives the pins; 250 MHz clock, synchronous reset.
`timescale 1ns/10ps
module tb_drive_pulse_output_and_input_status;
   localparam int PRESENT = 6;  // Fewer inputs than eight so masking is seen
   logic                            clk_sys = 0;
   logic                            reset = 1;
   drive_io_pkg::drive_quantities_t quant = '0;
   drive_io_pkg::scale_settings_t   scales = {16'd1000, 16'd300, 16'd500};
   drive_io_pkg::pulse_config_t     pcfg = '0;
   logic                            out_func = 0;
   logic                            pin_enable = 0;
   logic                            fs_write = 0;
   logic                            rx_clr = 1;
   logic [3:0]                      level = 4'h0;
   logic [47:0]                     func_sel = '0;
   logic [7:0]                      raw = 8'hFF;
   logic [7:0]                      pins;
   logic                            do2, po_act;
   logic [15:0]                     freq;
   logic [7:0]                      status, old;
   logic [47:0]                     func_act, exp_fn;
   int                              error_cnt = 0;
   int                              compares = 0;
   int                              seed, rises;
   int                              codes [10] = '{0, 2, 5, 7, 11, 12, 18, 19, 20, 1};

   always #2 clk_sys = ~clk_sys;

   drive_pulse_output_and_input_status #(.NUM_PRESENT(PRESENT)) DUT
   (
      .CLK_SYS(clk_sys), .RESET(reset), .QUANTITIES(quant), .SCALES(scales),
      .PULSE_CONFIG(pcfg), .TRANSISTOR_OUT_FUNCTION(out_func),
      .PULSE_IN_ENABLE(pin_enable), .INPUT_ACTIVE_LEVEL_SELECT(level),
      .INPUT_FUNCTION_SELECT(func_sel), .FUNCTION_SELECT_WRITE(fs_write),
      .NUMBERED_INPUT_PIN(pins), .TRANSISTOR_OUTPUT_TWO(do2), .PULSE_OUT_ACTIVE(po_act),
      .PULSE_OUT_FREQ_HZ(freq), .INPUT_STATUS_BYTE(status), .INPUT_FUNCTION_ACTIVE(func_act)
   );

   field_equipment FIELD
   (
      .clk(clk_sys), .clr(rx_clr), .raw_level(raw), .out_pin(do2), .pins(pins),
      .rise_cnt(rises)
   );

   // Single comparison point; four-state equality so unknowns fail
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Waits whole cycles, then steps past the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Status model: clamp level, pick polarity per input, drop absent inputs
   function automatic logic [7:0] exp_status(logic [7:0] r, int lvl, logic pie);
      logic [7:0] s;
      int         n;
      n = (lvl > 8) ? 8 : lvl;
      for (int i = 0; i < 8; i++)
         s[i] = (i < PRESENT) && ((i < n) ? r[i] : !r[i]);
      if (pie)
         s[1] = 1'b0;
      return s;
   endfunction

   // Full scale of each source in the units the bench drives
   function automatic longint full_scale(int code);
      case (code)
         0, 2:    return 1000;
         5, 7:    return 600;
         11:      return 2000;
         default: return 32767;
      endcase
   endfunction

   // Frequency model: min plus span times clipped fraction; unused code 1 gives min
   function automatic longint exp_freq(int code, longint v, longint g, longint mn, longint mx);
      longint num, den;
      num = v * g;
      den = full_scale(code) * 1000;
      if (code == 1)
         return mn;
      if (num >= den)
         return mx;
      return mn + (mx - mn) * num / den;
   endfunction

   // Applies one pulse source setting at a clock edge
   task automatic set_pulse(input int code, input logic [15:0] v, input logic [13:0] g,
                            input logic [14:0] mn, input logic [14:0] mx);
      drive_io_pkg::drive_quantities_t q;
      drive_io_pkg::pulse_config_t     c;
      q = '0;
      c = '0;
      c.pulse_out_source_select = code[4:0];
      c.pulse_out_gain = g;
      c.pulse_out_min_freq = mn;
      c.pulse_out_max_freq = mx;
      case (code)
         0:  q.speed_ref = v;
         2:  q.real_speed = v;
         5:  q.out_current = v;
         7:  q.act_current = v;
         11: q.torque = v;
         12: q.user_prog = v;
         18: c.user_output_value_a = v;
         19: c.user_output_value_b = v;
         20: c.user_output_value_c = v;
         default: q.speed_ref = v;
      endcase
      @(posedge clk_sys);
      quant <= q;
      pcfg <= c;
      tick(5);
      check(po_act, 1'b1);
      check(freq, exp_freq(code, v, g, mn, mx));
   endtask

   initial
   begin
      seed = 32'h6e90_038b;
      pcfg.pulse_out_source_select = drive_io_pkg::SOURCE_RESET;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      tick(3);
      check(po_act, 1'b0);
      check(status, 8'h00);
      check(func_act, {24'h0, drive_io_pkg::FUNC4_RESET, drive_io_pkg::FUNC3_RESET,
                       drive_io_pkg::FUNC2_RESET, drive_io_pkg::FUNC1_RESET});
      $display("test reset done");
      // Digital mode follows the function level one edge later
      repeat (8)
      begin
         @(posedge clk_sys);
         out_func <= 1'($random(seed));
         tick(3);
         check(do2, out_func);
      end
      $display("test digital output done");
      // Every level code plus one beyond range, random pins
      for (int l = 0; l < 10; l++)
         repeat (3)
         begin
            old = status;
            @(posedge clk_sys);
            level <= l[3:0];
            raw <= 8'($random(seed));
            tick(2);
            check(status, old);
            tick(4);
            check(status, exp_status(raw, l, 1'b0));
         end
      $display("test input status done");
      // Pulse input masks input two; selector writes refuse out-of-range fields
      @(posedge clk_sys);
      pin_enable <= 1'b1;
      raw <= 8'h02;
      level <= 4'h8;
      tick(6);
      check(status, exp_status(8'h02, 8, 1'b1));
      exp_fn = {24'h0, drive_io_pkg::FUNC4_RESET, drive_io_pkg::FUNC3_RESET,
                drive_io_pkg::FUNC2_RESET, drive_io_pkg::FUNC1_RESET};
      @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
         func_sel[6*i +: 6] <= (i == 3) ? 6'h3F : 6'($unsigned($random(seed)) % 47);
      fs_write <= 1'b1;
      @(posedge clk_sys);
      fs_write <= 1'b0;
      for (int i = 0; i < 8; i++)
         if (i != 3)
            exp_fn[6*i +: 6] = func_sel[6*i +: 6];
      tick(3);
      check(func_act, {exp_fn[47:12], 6'h00, exp_fn[5:0]});
      @(posedge clk_sys);
      pin_enable <= 1'b0;
      tick(3);
      check(func_act, exp_fn);
      $display("test selectors done");
      // Each code in codes (not 6, 9 or 16) at zero and full scale, then quarter scale with gain two
      foreach (codes[k])
      begin
         set_pulse(codes[k], 16'h0000, 14'd1000, 15'd10, 15'd10010);
         set_pulse(codes[k], 16'(full_scale(codes[k])), 14'd1000, 15'd10, 15'd10010);
      end
      set_pulse(0, 16'd250, 14'd2000, 15'd10, 15'd10010);
      // Pulse train at the top frequency: half period 6250 cycles
      set_pulse(0, 16'd1000, 14'd1000, 15'd20000, 15'd20000);
      @(posedge clk_sys);
      rx_clr <= 1'b0;
      tick(26000);
      check((rises >= 2) && (rises <= 3), 1'b1);
      $display("test pulse output done");
      finish_test();
   end
endmodule
